//--- eeprom_front_pkg.sv
package eeprom_front_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Clock and timing
   localparam int unsigned CLK_SYS_HZ = 25_000_000;
   localparam int unsigned CLK_SYS_PER_MS = CLK_SYS_HZ / 1000;
   // Longest program cycle, rounded down to whole system clock cycles
   localparam int unsigned PROGRAM_CYCLE_TIME_MS = 10;
   localparam int unsigned PROGRAM_CYCLE_CYCLES = PROGRAM_CYCLE_TIME_MS * CLK_SYS_PER_MS;
   // Settling the controller must allow after power-up; kept for reference
   localparam int unsigned POWERUP_READ_DELAY_MS = 1;
   localparam int unsigned POWERUP_WRITE_DELAY_MS = 1;
   // Samples a bus line must hold before the filtered level follows it
   localparam int unsigned LINE_FILTER_LEN = 3;

   ////////////////////////////////////////////////////////////////////////////
   // Address byte layout
   localparam logic [3:0] DEVICE_TYPE_CODE = 4'h5; // Arbitrary value
   localparam int unsigned TYPE_MSB = 7;
   localparam int unsigned TYPE_LSB = 4;
   localparam int unsigned SEL_MSB = 3;
   localparam int unsigned SEL_LSB = 1;
   localparam int unsigned DIR_BIT = 0;
   localparam logic DIR_READ = 1'b1;
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;
   localparam logic [7:0] IDLE_BYTE = 8'hff;

   ////////////////////////////////////////////////////////////////////////////
   // Density variants and the strap bits each one compares
   localparam logic [2:0] DENS_1K = 3'h0;
   localparam logic [2:0] DENS_2K = 3'h1;
   localparam logic [2:0] DENS_4K = 3'h2;
   localparam logic [2:0] DENS_8K = 3'h3;
   localparam logic [2:0] DENS_16K = 3'h4;
   localparam logic [2:0] MASK_ALL = 3'h7;
   localparam logic [2:0] MASK_UPPER2 = 3'h6;
   localparam logic [2:0] MASK_TOP1 = 3'h4;
   localparam logic [2:0] MASK_NONE = 3'h0;

   function automatic logic [2:0] strap_mask(input logic [2:0] dens);
      logic [2:0] m;
      m = MASK_ALL;
      if (dens == DENS_4K) begin
         m = MASK_UPPER2;
      end else if (dens == DENS_8K) begin
         m = MASK_TOP1;
      end else if (dens == DENS_16K) begin
         m = MASK_NONE;
      end
      return m;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Kinds of received byte reported to the user side
   localparam logic [1:0] KIND_SLAVE = 2'h0;
   localparam logic [1:0] KIND_WORD = 2'h1;
   localparam logic [1:0] KIND_DATA = 2'h2;

   // Bus engine states
   typedef enum logic [7:0] {
      ST_IDLE     = 8'h01,
      ST_RX_SLAVE = 8'h02,
      ST_RX_WORD  = 8'h04,
      ST_RX_DATA  = 8'h08,
      ST_ACK      = 8'h10,
      ST_TX       = 8'h20,
      ST_MACK     = 8'h40,
      ST_IGNORE   = 8'h80
   } link_state_e;

endpackage

//--- bit_sync.sv
`timescale 1ns/1ps
module bit_sync #(
   parameter int unsigned WIDTH = 1,
   parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
   // Destination clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Asynchronous levels in, synchronised levels out
   input wire logic [WIDTH-1:0] din,
   output logic [WIDTH-1:0] dout
);

   logic [WIDTH-1:0] meta;

   // Two flip-flops; only the second stage is read outside
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta <= RESET_VALUE;
         dout <= RESET_VALUE;
      end else begin
         meta <= din;
         dout <= meta;
      end
   end

endmodule

//--- program_timer.sv
`timescale 1ns/1ps
module program_timer #(
   parameter int unsigned CYCLES = 250000
) (
   // System clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // One-cycle start request and running flag
   input wire logic start,
   output logic busy
);

   localparam int unsigned CNT_W = $clog2(CYCLES + 1);

   logic [CNT_W-1:0] remaining;

   // Self-timed count; a start while already running is ignored
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         busy <= 1'b0;
         remaining <= '0;
      end else if (start && !busy) begin
         busy <= 1'b1;
         remaining <= CNT_W'(CYCLES - 1);
      end else if (busy) begin
         if (remaining == '0) begin
            busy <= 1'b0;
         end else begin
            remaining <= remaining - 1'b1;
         end
      end
   end

endmodule

//--- eeprom_bus_front.sv
// Function
// - Program cycle starts at stop, bounded time
// - Busy programming: release line, ignore address
// - Data line driven open-drain only
// - Unconnected straps read as zero
// - Density decides which straps are compared
// - Eight, four, two or one device per bus
// - Write-protect high makes array read-only
// - Data change while clock high is condition
// - Start is data fall, clock high
// - Stop is data rise, clock high
// - Upper nibble must match device type
// - Uncompared select bits become array address
// - Address bit zero selects read/write
// - Matching address acknowledged, then transfer
// - Receiver acknowledges on ninth clock
// - Protected: ack addresses, nack first data
`timescale 1ns/1ps
module eeprom_bus_front
   import eeprom_front_pkg::*;
#(
   parameter logic [2:0] DENSITY = eeprom_front_pkg::DENS_2K,
   parameter int unsigned PROG_CYCLES = eeprom_front_pkg::PROGRAM_CYCLE_CYCLES,
   parameter int unsigned FILTER_LEN = eeprom_front_pkg::LINE_FILTER_LEN
) (
   // System clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // Link clock that oversamples the bus
   input wire logic link_clk,
   // Two-wire bus pins
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe_n,
   // Strap and protect pins
   input wire logic strap_select_bit0,
   input wire logic strap_select_bit1,
   input wire logic strap_select_bit2,
   input wire logic write_protect,
   // Received bytes, system domain
   output logic byte_strobe,
   output logic [1:0] byte_kind,
   output logic [7:0] byte_value,
   output logic access_read,
   output logic array_addr_bit8,
   output logic array_addr_bit9,
   output logic array_addr_bit10,
   // Read data supply, system domain
   output logic read_byte_req,
   input wire logic [7:0] read_data,
   input wire logic read_data_valid,
   // Program cycle, system domain
   output logic program_start,
   output logic program_busy
);
   import eeprom_front_pkg::*;

   localparam int unsigned FW = $clog2(FILTER_LEN + 1);
   localparam logic [2:0] SEL_MASK = strap_mask(DENSITY);

   ////////////////////////////////////////////////////////////////////////////
   // Reset release, one copy per clock domain
   logic rst_sys_meta;
   logic rst_sys_n;
   logic rst_link_meta;
   logic rst_link_n;

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         rst_sys_meta <= 1'b0;
         rst_sys_n <= 1'b0;
      end else begin
         rst_sys_meta <= 1'b1;
         rst_sys_n <= rst_sys_meta;
      end
   end

   always_ff @(posedge link_clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_link_meta <= 1'b0;
         rst_link_n <= 1'b0;
      end else begin
         rst_link_meta <= 1'b1;
         rst_link_n <= rst_link_meta;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Link domain: pin capture and filtering
   logic [1:0] line_sync;
   logic [1:0] line_filt;
   logic [3:0] strap_sync;
   logic [1:0] to_link_sync;
   logic scl_prev;
   logic sda_prev;

   // bus synchronisers; idle level is high
   bit_sync #(.WIDTH(2), .RESET_VALUE(2'h3)) u_line_sync (
      .clk(link_clk),
      .rst_n(rst_link_n),
      .din({scl_in, sda_in}),
      .dout(line_sync)
   );

   // floating straps rely on pad pull-downs and reset to zero
   bit_sync #(.WIDTH(4), .RESET_VALUE(4'h0)) u_strap_sync (
      .clk(link_clk),
      .rst_n(rst_link_n),
      .din({write_protect, strap_select_bit2, strap_select_bit1, strap_select_bit0}),
      .dout(strap_sync)
   );

   // Filtered line follows only a level held FILTER_LEN samples
   for (genvar g = 0; g < 2; g++) begin : g_filt
      logic [FW-1:0] run;
      logic filt;
      // oversampling rejects spikes shorter than the filter
      always_ff @(posedge link_clk or negedge rst_link_n) begin
         if (!rst_link_n) begin
            run <= '0;
            filt <= 1'b1;
         end else if (line_sync[g] == filt) begin
            run <= '0;
         end else if (run == FW'(FILTER_LEN - 1)) begin
            run <= '0;
            filt <= line_sync[g];
         end else begin
            run <= run + 1'b1;
         end
      end
      assign line_filt[g] = filt;
   end

   logic scl_f;
   logic sda_f;
   logic wp_link;
   logic [2:0] strap_bits;
   assign scl_f = line_filt[1];
   assign sda_f = line_filt[0];
   assign wp_link = strap_sync[3];
   assign strap_bits = strap_sync[2:0];

   // Previous filtered levels for edge and condition detection
   always_ff @(posedge link_clk or negedge rst_link_n) begin
      if (!rst_link_n) begin
         scl_prev <= 1'b1;
         sda_prev <= 1'b1;
      end else begin
         scl_prev <= scl_f;
         sda_prev <= sda_f;
      end
   end

   logic scl_rise;
   logic scl_fall;
   logic start_cond;
   logic stop_cond;
   assign scl_rise = scl_f && !scl_prev;
   assign scl_fall = !scl_f && scl_prev;
   // data moving under a high clock is always a condition
   // start is data falling with clock high
   assign start_cond = scl_f && scl_prev && sda_prev && !sda_f;
   // stop is data rising with clock high
   assign stop_cond = scl_f && scl_prev && !sda_prev && sda_f;

   ////////////////////////////////////////////////////////////////////////////
   // Link domain: address decode
   logic [7:0] shreg;
   logic type_match;
   logic strap_match;
   assign type_match = shreg[TYPE_MSB:TYPE_LSB] == DEVICE_TYPE_CODE;
   assign strap_match = ((shreg[SEL_MSB:SEL_LSB] ^ strap_bits) & SEL_MASK) == 3'h0;

   ////////////////////////////////////////////////////////////////////////////
   // Link domain: bus engine
   link_state_e state;
   link_state_e after_ack;
   logic [3:0] bit_cnt;
   logic [7:0] tx_reg;
   logic write_pending;
   logic launch_pending;
   logic mack_ok;
   logic rx_toggle;
   logic [7:0] rx_hold;
   logic [1:0] rx_kind;
   logic rd_req_toggle;
   logic prog_toggle;
   logic busy_link;
   logic rd_ack_link;
   logic bus_busy;
   logic [7:0] rd_hold;
   logic [7:0] tx_first;

   assign busy_link = to_link_sync[0];
   assign rd_ack_link = to_link_sync[1];
   // Stop-to-timer latency is covered by the launch flag
   assign bus_busy = launch_pending || busy_link;
   // Stale data is never sent: without a fresh answer the line stays released
   assign tx_first = (rd_ack_link == rd_req_toggle) ? rd_hold : IDLE_BYTE;

   always_ff @(posedge link_clk or negedge rst_link_n) begin
      if (!rst_link_n) begin
         state <= ST_IDLE;
         after_ack <= ST_IDLE;
         bit_cnt <= 4'h0;
         shreg <= 8'h00;
         tx_reg <= IDLE_BYTE;
         sda_oe_n <= 1'b1;
         write_pending <= 1'b0;
         mack_ok <= 1'b0;
         rx_toggle <= 1'b0;
         rx_hold <= 8'h00;
         rx_kind <= KIND_SLAVE;
         rd_req_toggle <= 1'b0;
         prog_toggle <= 1'b0;
      end else if (start_cond) begin
         // A start, repeated or not, reopens address reception
         state <= ST_RX_SLAVE;
         bit_cnt <= 4'h0;
         sda_oe_n <= 1'b1;
         write_pending <= 1'b0;
      end else if (stop_cond) begin
         state <= ST_IDLE;
         sda_oe_n <= 1'b1;
         write_pending <= 1'b0;
         // program cycle launched by stop ending a write
         if (write_pending) begin
            prog_toggle <= ~prog_toggle;
         end
      end else begin
         unique case (state)
            // nothing is looked at before a start
            ST_IDLE, ST_IGNORE: begin
               sda_oe_n <= 1'b1;
            end
            ST_RX_SLAVE, ST_RX_WORD, ST_RX_DATA: begin
               if (scl_rise && bit_cnt != BITS_PER_BYTE) begin
                  shreg <= {shreg[6:0], sda_f};
                  bit_cnt <= bit_cnt + 1'b1;
               end else if (scl_fall && bit_cnt == BITS_PER_BYTE) begin
                  bit_cnt <= 4'h0;
                  rx_hold <= shreg;
                  if (state == ST_RX_SLAVE) begin
                     // busy device leaves its address unanswered
                     if (type_match && strap_match && !bus_busy) begin
                        sda_oe_n <= 1'b0;
                        state <= ST_ACK;
                        rx_kind <= KIND_SLAVE;
                        rx_toggle <= ~rx_toggle;
                        if (shreg[DIR_BIT] == DIR_READ) begin
                           after_ack <= ST_TX;
                           rd_req_toggle <= ~rd_req_toggle;
                        end else begin
                           after_ack <= ST_RX_WORD;
                        end
                     end else begin
                        state <= ST_IGNORE;
                     end
                  end else if (state == ST_RX_WORD) begin
                     // byte address acknowledged even when protected
                     sda_oe_n <= 1'b0;
                     state <= ST_ACK;
                     after_ack <= ST_RX_DATA;
                     rx_kind <= KIND_WORD;
                     rx_toggle <= ~rx_toggle;
                  end else if (wp_link) begin
                     // protected data is refused, nothing programmed
                     state <= ST_IGNORE;
                  end else begin
                     sda_oe_n <= 1'b0;
                     state <= ST_ACK;
                     after_ack <= ST_RX_DATA;
                     rx_kind <= KIND_DATA;
                     rx_toggle <= ~rx_toggle;
                     write_pending <= 1'b1;
                  end
               end
            end
            ST_ACK: begin
               if (scl_fall) begin
                  state <= after_ack;
                  if (after_ack == ST_TX) begin
                     // a zero bit pulls low, a one releases
                     sda_oe_n <= tx_first[7];
                     tx_reg <= {tx_first[6:0], 1'b1};
                     bit_cnt <= 4'h1;
                  end else begin
                     sda_oe_n <= 1'b1;
                     bit_cnt <= 4'h0;
                  end
               end
            end
            ST_TX: begin
               if (scl_fall) begin
                  if (bit_cnt == BITS_PER_BYTE) begin
                     sda_oe_n <= 1'b1;
                     state <= ST_MACK;
                  end else begin
                     sda_oe_n <= tx_reg[7];
                     tx_reg <= {tx_reg[6:0], 1'b1};
                     bit_cnt <= bit_cnt + 1'b1;
                  end
               end
            end
            ST_MACK: begin
               if (scl_rise) begin
                  // controller acknowledge asks for the next byte
                  mack_ok <= !sda_f;
                  if (!sda_f) begin
                     rd_req_toggle <= ~rd_req_toggle;
                  end
               end else if (scl_fall) begin
                  if (mack_ok) begin
                     state <= ST_TX;
                     sda_oe_n <= tx_first[7];
                     tx_reg <= {tx_first[6:0], 1'b1};
                     bit_cnt <= 4'h1;
                  end else begin
                     // No acknowledge: wait for the stop
                     state <= ST_IGNORE;
                  end
               end
            end
         endcase
      end
   end

   // Launch flag covers the gap until the timer's busy arrives
   always_ff @(posedge link_clk or negedge rst_link_n) begin
      if (!rst_link_n) begin
         launch_pending <= 1'b0;
      end else if (stop_cond && write_pending) begin
         launch_pending <= 1'b1;
      end else if (busy_link) begin
         launch_pending <= 1'b0;
      end
   end

   // open-drain: the driven level is always low
   always_ff @(posedge link_clk or negedge rst_link_n) begin
      if (!rst_link_n) begin
         sda_out <= 1'b0;
      end else begin
         sda_out <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Crossings between domains
   logic [2:0] to_sys_sync;
   logic [2:0] to_sys_seen;
   logic rd_ack_toggle;

   bit_sync #(.WIDTH(3), .RESET_VALUE(3'h0)) u_to_sys (
      .clk(clk_sys),
      .rst_n(rst_sys_n),
      .din({prog_toggle, rd_req_toggle, rx_toggle}),
      .dout(to_sys_sync)
   );

   bit_sync #(.WIDTH(2), .RESET_VALUE(2'h0)) u_to_link (
      .clk(link_clk),
      .rst_n(rst_link_n),
      .din({rd_ack_toggle, program_busy}),
      .dout(to_link_sync)
   );

   // Toggle edges become one-cycle events in the system domain
   always_ff @(posedge clk_sys or negedge rst_sys_n) begin
      if (!rst_sys_n) begin
         to_sys_seen <= 3'h0;
      end else begin
         to_sys_seen <= to_sys_sync;
      end
   end

   logic rx_event;
   logic rd_event;
   logic prog_event;
   assign rx_event = to_sys_sync[0] ^ to_sys_seen[0];
   assign rd_event = to_sys_sync[1] ^ to_sys_seen[1];
   assign prog_event = to_sys_sync[2] ^ to_sys_seen[2];

   ////////////////////////////////////////////////////////////////////////////
   // System domain: user side
   // Held link words are stable for a whole byte time when the toggle lands
   always_ff @(posedge clk_sys or negedge rst_sys_n) begin
      if (!rst_sys_n) begin
         byte_strobe <= 1'b0;
         byte_kind <= KIND_SLAVE;
         byte_value <= 8'h00;
         access_read <= 1'b0;
         array_addr_bit8 <= 1'b0;
         array_addr_bit9 <= 1'b0;
         array_addr_bit10 <= 1'b0;
      end else begin
         byte_strobe <= rx_event;
         if (rx_event) begin
            byte_kind <= rx_kind;
            byte_value <= rx_hold;
            if (rx_kind == KIND_SLAVE) begin
               access_read <= rx_hold[DIR_BIT];
               // uncompared select bits carry array address
               array_addr_bit8 <= rx_hold[SEL_LSB] & ~SEL_MASK[0];
               array_addr_bit9 <= rx_hold[SEL_LSB + 1] & ~SEL_MASK[1];
               array_addr_bit10 <= rx_hold[SEL_MSB] & ~SEL_MASK[2];
            end
         end
      end
   end

   // Read handshake: request out, data captured, toggle answered
   always_ff @(posedge clk_sys or negedge rst_sys_n) begin
      if (!rst_sys_n) begin
         read_byte_req <= 1'b0;
         rd_hold <= IDLE_BYTE;
         rd_ack_toggle <= 1'b0;
      end else begin
         read_byte_req <= rd_event;
         if (read_data_valid) begin
            rd_hold <= read_data;
            rd_ack_toggle <= to_sys_seen[1];
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rst_sys_n) begin
      if (!rst_sys_n) begin
         program_start <= 1'b0;
      end else begin
         program_start <= prog_event && !program_busy;
      end
   end

   // self-timed cycle bounded by the program cycle time
   program_timer #(.CYCLES(PROG_CYCLES)) u_program_timer (
      .clk(clk_sys),
      .rst_n(rst_sys_n),
      .start(program_start),
      .busy(program_busy)
   );

endmodule

//--- eeprom_front_assertions.sv
`timescale 1ns/1ps
module eeprom_front_checker #(
   parameter int unsigned PROG_CYCLES = 64
) (
   // Clocks and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic link_clk,
   // Bus pins
   input wire logic scl_in,
   input wire logic sda_out,
   input wire logic sda_oe_n,
   // User side
   input wire logic byte_strobe,
   input wire logic access_read,
   input wire logic array_addr_bit8,
   input wire logic array_addr_bit9,
   input wire logic array_addr_bit10,
   input wire logic read_byte_req,
   input wire logic program_start,
   input wire logic program_busy
);
   int unsigned busy_cnt;

   // Length of the current busy stretch
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         busy_cnt <= 0;
      end else begin
         busy_cnt <= program_busy ? busy_cnt + 1 : 0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Program cycle and user side, system side
   a_prog_launch: assert property (
      @(posedge clk_sys) disable iff (!rst_n) program_start |=> program_busy && !program_start)
      else $error("program start not followed by busy");
   a_busy_bounded: assert property (
      @(posedge clk_sys) disable iff (!rst_n) busy_cnt <= PROG_CYCLES)
      else $error("program cycle runs too long");
   a_strobe_gap: assert property (
      @(posedge clk_sys) disable iff (!rst_n) byte_strobe |=> !byte_strobe [*8])
      else $error("byte strobes too close");
   a_read_dir: assert property (
      @(posedge clk_sys) disable iff (!rst_n) read_byte_req |-> access_read)
      else $error("read request on a write access");
   // Only valid for a density that compares every strap
   a_addr_bits_zero: assert property (
      @(posedge clk_sys) disable iff (!rst_n) !array_addr_bit8 && !array_addr_bit9 && !array_addr_bit10)
      else $error("array bits set on full compare");

   ////////////////////////////////////////////////////////////////////////////
   // Data line, link side
   a_open_drain: assert property (
      @(posedge link_clk) disable iff (!rst_n) sda_out == 1'b0)
      else $error("data line driven high");
   a_busy_release: assert property (
      @(posedge link_clk) disable iff (!rst_n) program_busy |-> sda_oe_n)
      else $error("line pulled while programming");
   a_drive_clk_low: assert property (
      @(posedge link_clk) disable iff (!rst_n) $fell(sda_oe_n) |-> !scl_in)
      else $error("line pulled while clock high");
   a_ack_holds: assert property (
      @(posedge link_clk) disable iff (!rst_n) $fell(sda_oe_n) |=> !sda_oe_n [*8])
      else $error("pull released too early");

   c_prog: cover property (@(posedge clk_sys) disable iff (!rst_n) program_start);
   c_read: cover property (@(posedge clk_sys) disable iff (!rst_n) read_byte_req);
   c_pull: cover property (@(posedge link_clk) disable iff (!rst_n) $fell(sda_oe_n));
endmodule

bind eeprom_bus_front eeprom_front_checker #(.PROG_CYCLES(PROG_CYCLES)) u_chk (
   .clk_sys(clk_sys), .rst_n(rst_n), .link_clk(link_clk), .scl_in(scl_in),
   .sda_out(sda_out), .sda_oe_n(sda_oe_n), .byte_strobe(byte_strobe),
   .access_read(access_read), .array_addr_bit8(array_addr_bit8),
   .array_addr_bit9(array_addr_bit9), .array_addr_bit10(array_addr_bit10),
   .read_byte_req(read_byte_req), .program_start(program_start), .program_busy(program_busy));

//--- bus_master.sv
`timescale 1ns/1ps
module bus_master (
   // Link clock and resolved data line
   input wire logic link_clk,
   input wire logic sda,
   // Driven lines, released high at rest
   output logic scl,
   output logic sda_drv
);
   initial begin
      scl = 1'b1;
      sda_drv = 1'b1;
   end

   // Quarter bit; slow enough for the input filter
   task automatic q();
      repeat (8) @(posedge link_clk);
   endtask

   // start only from idle or repeated
   task automatic start();
      sda_drv <= 1'b1;
      q();
      scl <= 1'b1;
      q();
      sda_drv <= 1'b0;
      q();
      scl <= 1'b0;
      q();
   endtask

   // every frame ends with a stop
   task automatic stop();
      sda_drv <= 1'b0;
      q();
      scl <= 1'b1;
      q();
      sda_drv <= 1'b1;
      q();
   endtask

   // data moves only while clock low
   task automatic bit_io(input logic b, output logic r);
      sda_drv <= b;
      q();
      scl <= 1'b1;
      q();
      r = sda;
      q();
      scl <= 1'b0;
      q();
   endtask

   task automatic xfer(input logic [7:0] tx, input logic ak, output logic [7:0] rx, output logic nack);
      for (int i = 7; i >= 0; i--) begin
         bit_io(tx[i], rx[i]);
      end
      bit_io(ak, nack);
   endtask
endmodule

//--- tb_top.sv
`timescale 1ns/1ps
module tb_top;
   import eeprom_front_pkg::*;
   localparam logic [7:0] ADDR_W = {DEVICE_TYPE_CODE, 3'h5, 1'b0};
   logic clk_sys, link_clk, rst_n, wp, scl, m_sda, read_data_valid, nack;
   logic [2:0] strap;
   logic [7:0] read_data, rx, last_val, byte_value;
   logic [1:0] last_kind, byte_kind;
   logic sda_out, sda_oe_n, byte_strobe, access_read, hi8, hi9, hi10, read_byte_req, program_start, program_busy;
   wire sda_w = m_sda & (sda_oe_n | sda_out);
   int n_errors = 0;
   int tests_run = 0;
   int n_prog = 0;

   eeprom_bus_front #(.DENSITY(DENS_2K), .PROG_CYCLES(400), .FILTER_LEN(3)) u_dut (
      .clk_sys(clk_sys), .rst_n(rst_n), .link_clk(link_clk), .scl_in(scl), .sda_in(sda_w),
      .sda_out(sda_out), .sda_oe_n(sda_oe_n), .strap_select_bit0(strap[0]),
      .strap_select_bit1(strap[1]), .strap_select_bit2(strap[2]), .write_protect(wp),
      .byte_strobe(byte_strobe), .byte_kind(byte_kind), .byte_value(byte_value),
      .access_read(access_read), .array_addr_bit8(hi8), .array_addr_bit9(hi9),
      .array_addr_bit10(hi10), .read_byte_req(read_byte_req), .read_data(read_data),
      .read_data_valid(read_data_valid), .program_start(program_start), .program_busy(program_busy));

   bus_master u_master (.link_clk(link_clk), .sda(sda_w), .scl(scl), .sda_drv(m_sda));

   // Clocks, unrelated in phase
   initial begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end
   initial begin
      link_clk = 1'b0;
      #7;
      forever #16 link_clk = ~link_clk;
   end

   // Read supply answers each request with the next count
   always @(posedge clk_sys) begin
      read_data_valid <= read_byte_req;
      if (read_byte_req) read_data <= read_data + 8'h01;
      if (byte_strobe) last_kind <= byte_kind;
      if (byte_strobe) last_val <= byte_value;
      if (program_start) n_prog <= n_prog + 1;
   end

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [7:0] b);
      u_master.xfer(b, 1'b1, rx, nack);
   endtask

   task automatic stop_test();
      $display("errors=%0d compares=%0d", n_errors, tests_run);
      if (n_errors == 0 && tests_run > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   task automatic t_write();
      u_master.start();
      wr(ADDR_W);
      check(nack, 1'b0);
      check({last_kind, last_val}, {KIND_SLAVE, ADDR_W});
      wr(8'h3c);
      check(nack, 1'b0);
      check({last_kind, hi10, hi9, hi8}, {KIND_WORD, 3'h0});
      wr(8'ha7);
      check({last_kind, last_val}, {KIND_DATA, 8'ha7});
      u_master.stop();
      // Poll at once; programming keeps the device deaf
      u_master.start();
      wr(ADDR_W);
      check(nack, 1'b1);
      u_master.stop();
      check(n_prog, 1);
      check(program_busy, 1'b1);
      for (int i = 0; i < 1000 && program_busy; i++) @(posedge clk_sys);
      check(program_busy, 1'b0);
      u_master.start();
      wr(ADDR_W);
      check(nack, 1'b0);
      u_master.stop();
      $display("write test done");
   endtask

   task automatic t_refuse();
      logic [7:0] bad [4] = '{8'h6a, 8'h58, 8'h52, 8'h5e};
      foreach (bad[i]) begin
         u_master.start();
         wr(bad[i]);
         check(nack, 1'b1);
         wr(ADDR_W);
         check(nack, 1'b1);
         u_master.stop();
      end
      $display("refuse test done");
   endtask

   task automatic t_wp();
      @(posedge clk_sys) wp <= 1'b1;
      u_master.start();
      wr(ADDR_W);
      check(nack, 1'b0);
      wr(8'h10);
      check(nack, 1'b0);
      wr(8'h55);
      check(nack, 1'b1);
      u_master.stop();
      repeat (20) @(posedge clk_sys);
      check(n_prog, 1);
      wp <= 1'b0;
      $display("protect test done");
   endtask

   task automatic t_read();
      u_master.start();
      wr(ADDR_W | 8'h01);
      check(nack, 1'b0);
      check(access_read, 1'b1);
      u_master.xfer(8'hff, 1'b0, rx, nack);
      check(rx, 8'h96);
      u_master.xfer(8'hff, 1'b1, rx, nack);
      check(rx, 8'h97);
      u_master.stop();
      $display("read test done");
   endtask

   // Watchdog well beyond the expected run
   initial begin
      repeat (50000) @(posedge clk_sys);
      n_errors++;
      stop_test();
   end

   initial begin
      rst_n = 1'b0;
      wp = 1'b0;
      strap = 3'h5;
      read_data_valid = 1'b0;
      read_data = 8'h95;
      repeat (6) @(posedge clk_sys);
      rst_n <= 1'b1;
      repeat (50) @(posedge clk_sys);
      t_write();
      t_refuse();
      t_wp();
      t_read();
      stop_test();
   end
endmodule
